// ### tb/exception_queue_assertions.sv
/*
  Port checks for exception_queue.
  Assumes one clock; bound onto the design top.
*/
module exception_queue_assertions (
  // clock and reset
  input wire logic        clk, rstn,
  // register read
  input wire logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid,
  // exceptions and queue memory
  input wire logic        exc_ready, mem_req, mem_we, mem_ack,
  input wire logic [31:0] mem_rdata, mem_wdata,
  // slots and global errors
  input wire logic        tx_underrun, tx_slot_valid, tx_byte_valid, tx_fetch, rx_overrun, rx_store,
  input wire logic [7:0]  tx_byte
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence s_gun_slot;
    tx_underrun ##2 tx_slot_valid;
  endsequence
  sequence s_full_read;
    mem_req && !mem_we && mem_ack && mem_rdata[exq_pkg::ENT_V_BIT];
  endsequence
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer missing");
  poster_busy_a: assert property (mem_req |-> !exc_ready)
    else $error("exception taken while posting");
  entry_valid_a: assert property (mem_req && mem_we |-> mem_wdata[exq_pkg::ENT_V_BIT])
    else $error("entry written without valid");
  mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req)
    else $error("memory request dropped");
  overflow_drop_a: assert property (s_full_read |=> !mem_req)
    else $error("occupied entry overwritten");
  underrun_ones_a: assert property (s_gun_slot |=> tx_byte_valid && tx_byte == exq_pkg::ONES_BYTE && !tx_fetch)
    else $error("underrun abort missing");
  fetch_stop_a: assert property (tx_underrun |=> !tx_fetch [*8])
    else $error("fetch after underrun");
  store_stop_a: assert property (rx_overrun |=> !rx_store [*8])
    else $error("store after overrun");
endmodule

bind exception_queue exception_queue_assertions chk_u (.clk, .rstn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .exc_ready, .mem_req, .mem_we, .mem_ack, .mem_rdata, .mem_wdata, .tx_underrun, .tx_slot_valid,
  .tx_byte_valid, .tx_fetch, .rx_overrun, .rx_store, .tx_byte);

// ### tb/exception_queue_tb.sv
/*
  Self-checking bench for exception_queue.
  Assumes queue_memory_model serves the queue port.
*/
module exception_queue_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rstn = 0, exc_valid = 0, tx_underrun = 0, rx_overrun = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic        tx_slot_valid = 0, tx_slot_in_frame = 0, rx_slot_valid = 0, tx_buffer_done = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, tx_byte;
  logic [4:0]  exc_channel = 0, tx_slot_channel = 0, rx_slot_channel = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, mem_addr, mem_wdata, mem_rdata, ew[4];
  logic [15:0] exc_desc = 0;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, exc_ready;
  logic        tx_byte_valid, tx_fetch, rx_store, mem_req, mem_we, mem_ack, host_irq;
  logic [33:0] rq[$];
  logic [8:0]  tq[$];
  int          errors = 0, checks = 0;
  exception_queue dut (.*, .s_axi_wstrb(4'hf));
  queue_memory_model mem (.*);
  initial forever #10 clk = ~clk;
  initial begin
    #1_000_000;
    errors++;
    tally_and_finish();
  end
  task automatic chk(input string n, input logic [33:0] s, e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(negedge clk) begin
    if (s_axi_rvalid && s_axi_rready) chk("read", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (tx_byte_valid === 1'h1) chk("tx byte", {tx_fetch, tx_byte}, tq.pop_front());
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic da = 0, dw = 0;
    @(posedge clk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!(da && dw)) begin
      @(negedge clk);
      da |= s_axi_awready;
      dw |= s_axi_wready;
      @(posedge clk);
      {s_axi_awvalid, s_axi_wvalid} <= {!da, !dw};
    end
    do @(negedge clk); while (s_axi_bvalid !== 1'h1);
    chk("bresp", s_axi_bresp, exq_pkg::RESP_OKAY);
    @(posedge clk);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    rq.push_back({r, e});
    do @(negedge clk); while (s_axi_arready !== 1'h1);
    @(posedge clk);
    s_axi_arvalid <= 1'h0;
    do @(negedge clk); while (s_axi_rvalid !== 1'h1);
    @(posedge clk);
    s_axi_rready <= 1'h0;
  endtask
  task automatic post(input logic [4:0] c, input logic [15:0] d);
    @(posedge clk);
    {exc_valid, exc_channel, exc_desc} <= {1'h1, c, d};
    do @(negedge clk); while (exc_ready !== 1'h1);
    @(posedge clk);
    exc_valid <= 1'h0;
    do @(negedge clk); while (exc_ready !== 1'h1);
  endtask
  task automatic slot(input logic rx, input logic [4:0] c, input logic f, input logic [8:0] e);
    @(posedge clk);
    {tx_slot_valid, rx_slot_valid, tx_slot_in_frame, tx_buffer_done} <= {!rx, rx, f, !rx && f};
    {tx_slot_channel, rx_slot_channel} <= {c, c};
    if (!rx) tq.push_back(e);
    @(posedge clk);
    {tx_slot_valid, rx_slot_valid, tx_buffer_done} <= 3'h0;
    @(negedge clk);
    if (rx) chk("rx store", rx_store, e);
  endtask
  task automatic err(input logic u);
    @(posedge clk);
    {tx_underrun, rx_overrun} <= {u, !u};
    @(posedge clk);
    {tx_underrun, rx_overrun} <= 2'h0;
  endtask
  task automatic cmd(input logic [2:0] op, input logic [4:0] c);
    wr(8'h00, 32'({2'h2, c, 5'h0, op, 1'h0}));
    repeat (3) @(posedge clk);
    rd(8'h00, 32'({c, 5'h0, op, 1'h0}));
  endtask
  initial begin
    logic [4:0]  c;
    logic [15:0] d;
    void'($urandom(90));
    repeat (10) @(posedge clk);
    rstn <= 1'h1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 6; i++) if (i != 4) rd(8'(4 * i), 32'h0);
    rd(8'h20, 32'h0, exq_pkg::RESP_DECERR);
    wr(8'h14, 32'h0000_ffff);
    wr(8'h08, 32'h0000_000f);
    for (int i = 0; i < 4; i++) begin
      c = 5'($urandom);
      d = 16'($urandom) | 16'h0001;
      ew[i] = {d, 1'h1, i == 3, 9'h0, c};
      post(c, d);
    end
    foreach (ew[i]) chk("entry", mem.words[i], ew[i]);
    rd(8'h10, 32'h0);
    rd(8'h04, 32'h2);
    post(5'h1, 16'h0001);
    chk("kept", mem.words[0], ew[0]);
    wr(8'h04, 32'h0);
    rd(8'h04, 32'h3);
    chk("irq on", host_irq, 1'h1);
    wr(8'h08, 32'h0);
    chk("irq off", host_irq, 1'h0);
    wr(8'h04, 32'h3);
    rd(8'h04, 32'h0);
    foreach (ew[i]) mem.words[i] = (i == 3) ? 32'h0000_4000 : 32'h0;
    wr(8'h14, 32'h1);
    post(5'h2, 16'h0002);
    post(5'h2, 16'h0003);
    chk("masked", mem.words[0], 32'h0001_8002);
    rd(8'h10, 32'h4);
    wr(8'h18, 32'h005a_0703);
    slot(0, 3, 1, {1'h1, exq_pkg::FETCH_BYTE});
    cmd(exq_pkg::OP_STOP_TX, 5'h3);
    slot(0, 3, 1, {1'h0, exq_pkg::ABORT_BYTE});
    slot(0, 3, 0, {1'h0, exq_pkg::FLAG_BYTE});
    rd(8'h18, 32'h005b_0603);
    slot(1, 5, 0, 9'h1);
    cmd(exq_pkg::OP_STOP_RX, 5'h5);
    slot(1, 5, 0, 9'h0);
    wr(8'h1c, 32'h5);
    slot(1, 5, 0, 9'h1);
    err(1'h1);
    slot(0, 3, 1, {1'h0, exq_pkg::ONES_BYTE});
    slot(0, 3, 1, {1'h0, exq_pkg::ONES_BYTE});
    slot(0, 3, 0, {1'h0, exq_pkg::FLAG_BYTE});
    wr(8'h18, 32'h005a_0703);
    slot(0, 3, 0, {1'h1, exq_pkg::FETCH_BYTE});
    err(1'h0);
    slot(1, 5, 0, 9'h0);
    rd(8'h1c, 32'h0010_0003);
    rd(8'h04, 32'h0000_000e);
    tally_and_finish();
  end
endmodule

// ### tb/queue_memory_model.sv
/*
  External queue memory with random answer delay.
  Assumes requests are held until the acknowledge.
*/
module queue_memory_model (
  // queue port
  input wire logic        clk,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic [31:0]     mem_rdata,
  output logic            mem_ack
);
  logic [31:0] words [16];
  initial begin
    {mem_ack, mem_rdata} = 33'h0;
    foreach (words[i]) words[i] = 32'h0;
    words[3] = 32'h0000_4000;
    forever begin
      @(posedge clk);
      mem_ack <= 1'h0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack && $urandom_range(1, 0)) begin
        mem_ack <= 1'h1;
        if (mem_we) words[mem_addr[5:2]] <= mem_wdata;
        else mem_rdata <= words[mem_addr[5:2]];
      end
    end
  end
endmodule

// ### verilog/command_decoder.sv
/*
  Decodes a pending channel command into one-cycle stop pulses.
  Assumes the top clears the pending flag on the done pulse.
*/
module command_decoder (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // link to top
  exq_link.cmd      lnk
);
  typedef struct packed {
    logic                     done;
    logic                     stop_tx;
    logic                     stop_rx;
    logic [exq_pkg::CH_W-1:0] channel;
  } cmd_reg_type;
  cmd_reg_type s;
  cmd_reg_type n;
  logic [2:0]  op;
  assign op = lnk.cmd_word[exq_pkg::CMD_OP_LSB +: 3];
  always_comb begin
    n         = s;
    n.done    = 1'b0;
    n.stop_tx = 1'b0;
    n.stop_rx = 1'b0;
    if (lnk.cmd_valid && !s.done) begin
      n.done    = 1'b1;
      n.channel = lnk.cmd_word[exq_pkg::CMD_CH_LSB +: exq_pkg::CH_W];
      n.stop_tx = (op == exq_pkg::OP_STOP_TX);
      n.stop_rx = (op == exq_pkg::OP_STOP_RX);
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
  assign lnk.cmd_done    = s.done;
  assign lnk.stop_tx     = s.stop_tx;
  assign lnk.stop_rx     = s.stop_rx;
  assign lnk.cmd_channel = s.channel;
endmodule

// ### verilog/exception_queue.sv
/*
  Channel command handling, per-channel fill control, global error recovery
  and exception queue reporting behind an AXI4-Lite register slave.
  Assumes slot, exception and error inputs come from logic on the same clock.
*/
module exception_queue (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // channel exceptions
  input  wire logic        exc_valid,
  input  wire logic [4:0]  exc_channel,
  input  wire logic [15:0] exc_desc,
  output logic             exc_ready,
  // global fifo errors
  input  wire logic        tx_underrun,
  input  wire logic        rx_overrun,
  // transmit time slots
  input  wire logic        tx_slot_valid,
  input  wire logic [4:0]  tx_slot_channel,
  input  wire logic        tx_slot_in_frame,
  input  wire logic        tx_buffer_done,
  output logic             tx_byte_valid,
  output logic [7:0]       tx_byte,
  output logic             tx_fetch,
  // receive time slots
  input  wire logic        rx_slot_valid,
  input  wire logic [4:0]  rx_slot_channel,
  output logic             rx_store,
  // queue memory port
  output logic             mem_req,
  output logic             mem_we,
  output logic [31:0]      mem_addr,
  output logic [31:0]      mem_wdata,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        mem_ack,
  // host interrupt request
  output logic             host_irq
);
  localparam int N  = exq_pkg::NUM_CH;
  localparam int CW = exq_pkg::CH_W;
  localparam int EW = exq_pkg::EV_W;

  typedef struct packed {
    logic                                awready;
    logic                                wready;
    logic                                aw_have;
    logic                                w_have;
    logic [7:0]                          awaddr;
    logic [31:0]                         wdata;
    logic [3:0]                          wstrb;
    logic                                bvalid;
    logic [1:0]                          bresp;
    logic                                arready;
    logic                                rvalid;
    logic [31:0]                         rdata;
    logic [1:0]                          rresp;
    logic [15:0]                         cmd;
    logic [EW-1:0]                       ev;
    logic [EW-1:0]                       ev_mask;
    logic [exq_pkg::DESC_W-1:0]          q_mask;
    logic [31:0]                         q_base;
    logic [CW-1:0]                       sel;
    logic [N-1:0]                        poll;
    logic [N-1:0]                        enable;
    logic [N-1:0]                        idle_sel;
    logic [N-1:0]                        rx_stop;
    logic [N-1:0]                        hold;
    logic [N-1:0]                        in_frame;
    logic [N-1:0]                        ab_ones;
    logic [N-1:0][1:0]                   ab_cnt;
    logic [N-1:0][exq_pkg::PTR_W-1:0]    tx_ptr;
    logic                                tx_valid;
    logic [7:0]                          tx_byte;
    logic                                tx_fetch;
    logic                                rx_store;
    logic                                irq;
  } top_state_type;

  localparam top_state_type ST_RESET = '{cmd:     exq_pkg::CMD_RESET,
                                         ev_mask: exq_pkg::EVMASK_RESET,
                                         q_mask:  exq_pkg::QMASK_RESET,
                                         q_base:  exq_pkg::QBASE_RESET,
                                         default: '0};

  top_state_type s;
  top_state_type n;
  logic          wr_fire;

  exq_link lnk();

  queue_poster u_poster (
    .clk  (clk),
    .rstn (rstn),
    .lnk  (lnk)
  );

  command_decoder u_cmd (
    .clk  (clk),
    .rstn (rstn),
    .lnk  (lnk)
  );

  function automatic logic reg_known(input logic [7:0] a);
    reg_known = (a == exq_pkg::OFF_COMMAND) || (a == exq_pkg::OFF_EVENT) || (a == exq_pkg::OFF_EVMASK) ||
                (a == exq_pkg::OFF_QBASE) || (a == exq_pkg::OFF_QPTR) || (a == exq_pkg::OFF_QMASK) ||
                (a == exq_pkg::OFF_MODE) || (a == exq_pkg::OFF_RXSTATE);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        merge[8*b +: 8] = nw[8*b +: 8];
      end
    end
  endfunction

  assign wr_fire       = s.aw_have && s.w_have && !s.bvalid;
  assign lnk.ptr_load  = wr_fire && (s.awaddr == exq_pkg::OFF_QPTR);
  assign lnk.ptr_value = s.wdata;
  assign lnk.base      = s.q_base;
  assign lnk.exc_valid   = exc_valid && ((exc_desc & s.q_mask) != 16'h0000);
  assign lnk.exc_desc    = exc_desc & s.q_mask;
  assign lnk.exc_channel = exc_channel;
  assign lnk.mem_rdata = mem_rdata;
  assign lnk.mem_ack   = mem_ack;
  assign lnk.cmd_valid = s.cmd[exq_pkg::CMD_FLAG_BIT];
  assign lnk.cmd_word  = s.cmd;

  always_comb begin
    logic [CW-1:0] c;
    logic [31:0]   rd;
    c          = '0;
    rd         = '0;
    n          = s;
    n.tx_valid = 1'b0;
    n.tx_fetch = 1'b0;
    n.rx_store = 1'b0;
    // pending flag drops once the decoder has acted
    if (lnk.cmd_done) begin
      n.cmd[exq_pkg::CMD_FLAG_BIT] = 1'b0;
    end
    // axi write channels
    if (s_axi_awvalid && s.awready) begin
      n.aw_have = 1'b1;
      n.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      n.w_have = 1'b1;
      n.wdata  = s_axi_wdata;
      n.wstrb  = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (wr_fire) begin
      n.bvalid  = 1'b1;
      n.aw_have = 1'b0;
      n.w_have  = 1'b0;
      n.bresp   = reg_known(s.awaddr) ? exq_pkg::RESP_OKAY : exq_pkg::RESP_DECERR;
      c         = s.wdata[CW-1:0];
      unique case (s.awaddr)
        exq_pkg::OFF_COMMAND: begin
          n.cmd = 16'(merge(32'(s.cmd), s.wdata, s.wstrb));
        end
        exq_pkg::OFF_EVENT: begin
          if (s.wstrb[0]) begin
            n.ev = s.ev & ~s.wdata[EW-1:0];
          end
        end
        exq_pkg::OFF_EVMASK: begin
          n.ev_mask = EW'(merge(32'(s.ev_mask), s.wdata, s.wstrb));
        end
        exq_pkg::OFF_QBASE: begin
          n.q_base = merge(s.q_base, s.wdata, s.wstrb);
        end
        exq_pkg::OFF_QMASK: begin
          n.q_mask = 16'(merge(32'(s.q_mask), s.wdata, s.wstrb));
        end
        exq_pkg::OFF_MODE: begin
          n.sel         = c;
          n.poll[c]     = s.wdata[exq_pkg::MODE_POLL_BIT];
          n.enable[c]   = s.wdata[exq_pkg::MODE_ENABLE_BIT];
          n.idle_sel[c] = s.wdata[exq_pkg::MODE_IDLE_BIT];
          n.tx_ptr[c]   = s.wdata[exq_pkg::MODE_PTR_LSB +: exq_pkg::PTR_W];
          if (s.wdata[exq_pkg::MODE_POLL_BIT]) begin
            n.hold[c] = 1'b0;
          end
        end
        exq_pkg::OFF_RXSTATE: begin
          n.sel        = c;
          n.rx_stop[c] = s.wdata[exq_pkg::RX_STOP_BIT];
        end
        default: begin
        end
      endcase
    end
    n.awready = !n.aw_have;
    n.wready  = !n.w_have;
    // axi read channel
    unique case (s_axi_araddr)
      exq_pkg::OFF_COMMAND: rd = 32'(s.cmd);
      exq_pkg::OFF_EVENT:   rd = 32'(s.ev);
      exq_pkg::OFF_EVMASK:  rd = 32'(s.ev_mask);
      exq_pkg::OFF_QBASE:   rd = s.q_base;
      exq_pkg::OFF_QPTR:    rd = lnk.ptr;
      exq_pkg::OFF_QMASK:   rd = 32'(s.q_mask);
      exq_pkg::OFF_MODE: begin
        rd                                         = 32'(s.sel);
        rd[exq_pkg::MODE_POLL_BIT]                 = s.poll[s.sel];
        rd[exq_pkg::MODE_ENABLE_BIT]               = s.enable[s.sel];
        rd[exq_pkg::MODE_IDLE_BIT]                 = s.idle_sel[s.sel];
        rd[exq_pkg::MODE_PTR_LSB +: exq_pkg::PTR_W] = s.tx_ptr[s.sel];
      end
      exq_pkg::OFF_RXSTATE: begin
        rd                       = 32'(s.sel);
        rd[exq_pkg::RX_STOP_BIT] = s.rx_stop[s.sel];
      end
      default: rd = 32'h0000_0000;
    endcase
    if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s.arready) begin
      n.rvalid = 1'b1;
      n.rdata  = rd;
      n.rresp  = reg_known(s_axi_araddr) ? exq_pkg::RESP_OKAY : exq_pkg::RESP_DECERR;
    end
    n.arready = !n.rvalid;
    // transmit slot: abort bytes, buffer data or idle fill
    if (tx_slot_valid) begin
      c             = tx_slot_channel;
      n.tx_valid    = 1'b1;
      n.in_frame[c] = tx_slot_in_frame;
      if (s.ab_cnt[c] != 2'h0) begin
        n.ab_cnt[c] = s.ab_cnt[c] - 2'h1;
        n.tx_byte   = s.ab_ones[c] ? exq_pkg::ONES_BYTE : exq_pkg::ABORT_BYTE;
      end else if (s.poll[c] && s.enable[c] && !s.hold[c]) begin
        n.tx_fetch = 1'b1;
        n.tx_byte  = exq_pkg::FETCH_BYTE;
      end else begin
        n.tx_byte = s.idle_sel[c] ? exq_pkg::FLAG_BYTE : exq_pkg::IDLE_BYTE;
      end
    end
    // descriptor pointer moves only on a finished buffer
    if (tx_buffer_done && s.poll[tx_slot_channel] && !s.hold[tx_slot_channel]) begin
      n.tx_ptr[tx_slot_channel] = s.tx_ptr[tx_slot_channel] + 8'h01;
    end
    // receive slot
    if (rx_slot_valid) begin
      n.rx_store = !s.rx_stop[rx_slot_channel] && !rx_overrun;
    end
    // channel commands
    c = lnk.cmd_channel;
    if (lnk.stop_tx) begin
      n.poll[c] = 1'b0;
      if (s.in_frame[c]) begin
        n.ab_cnt[c]   = exq_pkg::STOP_ABORT_SLOTS;
        n.ab_ones[c]  = 1'b0;
        n.in_frame[c] = 1'b0;
      end
    end
    if (lnk.stop_rx) begin
      n.rx_stop[c] = 1'b1;
    end
    // global errors reach every channel
    for (int i = 0; i < N; i++) begin
      if (tx_underrun) begin
        n.ab_cnt[i]   = exq_pkg::UNDERRUN_SLOTS;
        n.ab_ones[i]  = 1'b1;
        n.hold[i]     = 1'b1;
        n.poll[i]     = 1'b0;
        n.in_frame[i] = 1'b0;
      end
      if (rx_overrun) begin
        n.rx_stop[i] = 1'b1;
      end
    end
    // event bits: hardware sets win over a clearing write
    if (lnk.posted) begin
      n.ev[exq_pkg::EV_GLOBAL_QUEUE_INTERRUPT] = 1'b1;
    end
    if (lnk.overflow) begin
      n.ev[exq_pkg::EV_QOVF] = 1'b1;
    end
    if (tx_underrun) begin
      n.ev[exq_pkg::EV_GUN] = 1'b1;
    end
    if (rx_overrun) begin
      n.ev[exq_pkg::EV_GOV] = 1'b1;
    end
    n.irq = |(n.ev & n.ev_mask);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= ST_RESET;
    end else begin
      s <= n;
    end
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready  = s.wready;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_arready = s.arready;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;
  assign s_axi_rvalid  = s.rvalid;
  assign exc_ready     = lnk.exc_ready;
  assign tx_byte_valid = s.tx_valid;
  assign tx_byte       = s.tx_byte;
  assign tx_fetch      = s.tx_fetch;
  assign rx_store      = s.rx_store;
  assign mem_req       = lnk.mem_req;
  assign mem_we        = lnk.mem_we;
  assign mem_addr      = lnk.mem_addr;
  assign mem_wdata     = lnk.mem_wdata;
  assign host_irq      = s.irq;
endmodule

// ### verilog/exq_link.sv
/*
  Link between the top block, its queue poster and its command decoder.
  Assumes all three ends run on the same clock.
*/
interface exq_link;
  logic        exc_valid;
  logic        exc_ready;
  logic [4:0]  exc_channel;
  logic [15:0] exc_desc;
  logic        ptr_load;
  logic [31:0] ptr_value;
  logic [31:0] base;
  logic [31:0] ptr;
  logic        posted;
  logic        overflow;
  logic        mem_req;
  logic        mem_we;
  logic [31:0] mem_addr;
  logic [31:0] mem_wdata;
  logic [31:0] mem_rdata;
  logic        mem_ack;
  logic        cmd_valid;
  logic [15:0] cmd_word;
  logic        cmd_done;
  logic        stop_tx;
  logic        stop_rx;
  logic [4:0]  cmd_channel;
  modport poster (input exc_valid, exc_channel, exc_desc, ptr_load, ptr_value, base, mem_rdata, mem_ack,
                  output exc_ready, ptr, posted, overflow, mem_req, mem_we, mem_addr, mem_wdata);
  modport cmd (input cmd_valid, cmd_word, output cmd_done, stop_tx, stop_rx, cmd_channel);
endinterface

// ### verilog/exq_pkg.sv
/*
  Constants, field layouts, register offsets and state codes for the channel
  command and exception queue block.
  Assumes a single 50 MHz clock domain and a 32-bit AXI4-Lite register bus.
*/
// Behaviour
// - command word: opcode, channel, pending flag bit 15
// - stop transmit 001 clears channel poll enable
// - mid-frame stop sends 7F, then idle/flags
// - stop transmit leaves descriptor pointer unchanged
// - stop receive 000 halts channel, keeps parameters
// - post entry at pointer, set valid, advance
// - entry with wrap bit reloads pointer base
// - only queue-mask surviving exceptions get posted
// - update event word; unmasked events raise interrupt
// - new queue entry sets global queue interrupt
// - underrun: sixteen ones abort, event bit set
// - after underrun send fill until re-armed
// - overrun marks every receiver stopped, bit 20
// - overrun sets event bit, stops storing data
// - event bits clear on write one only
// - occupied slot: flag queue overflow, drop entry
package exq_pkg;
  localparam int          CH_W     = 5;
  localparam int          NUM_CH   = 32;
  localparam int          DESC_W   = 16;
  localparam int          PTR_W    = 8;
  localparam int          EV_W     = 4;
  // register byte offsets
  localparam logic [7:0]  OFF_COMMAND = 8'h00;
  localparam logic [7:0]  OFF_EVENT   = 8'h04;
  localparam logic [7:0]  OFF_EVMASK  = 8'h08;
  localparam logic [7:0]  OFF_QBASE   = 8'h0c;
  localparam logic [7:0]  OFF_QPTR    = 8'h10;
  localparam logic [7:0]  OFF_QMASK   = 8'h14;
  localparam logic [7:0]  OFF_MODE    = 8'h18;
  localparam logic [7:0]  OFF_RXSTATE = 8'h1c;
  // field positions
  localparam int          CMD_FLAG_BIT    = 15;
  localparam int          CMD_OP_LSB      = 1;
  localparam int          CMD_CH_LSB      = 9;
  localparam int          EV_QOVF         = 0;
  localparam int          EV_GLOBAL_QUEUE_INTERRUPT         = 1;
  localparam int          EV_GUN          = 2;
  localparam int          EV_GOV          = 3;
  localparam int          ENT_V_BIT       = 15;
  localparam int          ENT_W_BIT       = 14;
  localparam int          RX_STOP_BIT     = 20;
  localparam int          MODE_POLL_BIT   = 8;
  localparam int          MODE_ENABLE_BIT = 9;
  localparam int          MODE_IDLE_BIT   = 10;
  localparam int          MODE_PTR_LSB    = 16;
  // codes and counts
  localparam logic [2:0]  OP_STOP_RX       = 3'h0;
  localparam logic [2:0]  OP_STOP_TX       = 3'h1;
  localparam logic [7:0]  ABORT_BYTE       = 8'h7f;
  localparam logic [7:0]  ONES_BYTE        = 8'hff;
  localparam logic [7:0]  IDLE_BYTE        = 8'hff;
  localparam logic [7:0]  FLAG_BYTE        = 8'h7e;
  localparam logic [7:0]  FETCH_BYTE       = 8'h00;
  localparam int          UNDERRUN_ONES    = 16;
  localparam logic [1:0]  UNDERRUN_SLOTS   = 2'(UNDERRUN_ONES / 8);
  localparam logic [1:0]  STOP_ABORT_SLOTS = 2'h1;
  localparam logic [31:0] ENTRY_BYTES      = 32'h0000_0004;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_DECERR      = 2'h3;
  // values after reset
  localparam logic [15:0] CMD_RESET    = 16'h0000;
  localparam logic [3:0]  EVMASK_RESET = 4'h0;
  localparam logic [15:0] QMASK_RESET  = 16'h0000;
  localparam logic [31:0] QBASE_RESET  = 32'h0000_0000;
  typedef enum logic [1:0] {
    P_IDLE  = 2'b00,
    P_READ  = 2'b01,
    P_WRITE = 2'b11,
    P_DONE  = 2'b10
  } post_state_type;
endpackage

// ### verilog/queue_poster.sv
/*
  Writes exception entries into the circular queue in external memory.
  Assumes a memory port that holds a request until a one-cycle acknowledge.
*/
module queue_poster (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // link to top
  exq_link.poster   lnk
);
  typedef struct packed {
    exq_pkg::post_state_type state;
    logic                    ready;
    logic [31:0]             ptr;
    logic [31:0]             entry;
    logic                    req;
    logic                    we;
    logic [31:0]             addr;
    logic                    posted;
    logic                    overflow;
  } post_reg_type;
  post_reg_type s;
  post_reg_type n;
  always_comb begin
    n          = s;
    n.posted   = 1'b0;
    n.overflow = 1'b0;
    if (lnk.ptr_load) begin
      n.ptr = lnk.ptr_value;
    end
    unique case (s.state)
      exq_pkg::P_IDLE: begin
        if (lnk.exc_valid && s.ready) begin
          n.entry = {lnk.exc_desc, 11'h000, lnk.exc_channel};
          n.addr  = n.ptr;
          n.req   = 1'b1;
          n.we    = 1'b0;
          n.state = exq_pkg::P_READ;
        end
      end
      exq_pkg::P_READ: begin
        if (lnk.mem_ack) begin
          if (lnk.mem_rdata[exq_pkg::ENT_V_BIT]) begin
            n.req      = 1'b0;
            n.overflow = 1'b1;
            n.state    = exq_pkg::P_IDLE;
          end else begin
            n.entry[exq_pkg::ENT_V_BIT] = 1'b1;
            n.entry[exq_pkg::ENT_W_BIT] = lnk.mem_rdata[exq_pkg::ENT_W_BIT];
            n.we                        = 1'b1;
            n.state                     = exq_pkg::P_WRITE;
          end
        end
      end
      exq_pkg::P_WRITE: begin
        if (lnk.mem_ack) begin
          n.req    = 1'b0;
          n.we     = 1'b0;
          n.posted = 1'b1;
          n.ptr    = s.entry[exq_pkg::ENT_W_BIT] ? lnk.base : s.ptr + exq_pkg::ENTRY_BYTES;
          n.state  = exq_pkg::P_DONE;
        end
      end
      exq_pkg::P_DONE: begin
        n.state = exq_pkg::P_IDLE;
      end
    endcase
    n.ready = (n.state == exq_pkg::P_IDLE);
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
  assign lnk.exc_ready = s.ready;
  assign lnk.ptr       = s.ptr;
  assign lnk.posted    = s.posted;
  assign lnk.overflow  = s.overflow;
  assign lnk.mem_req   = s.req;
  assign lnk.mem_we    = s.we;
  assign lnk.mem_addr  = s.addr;
  assign lnk.mem_wdata = s.entry;
endmodule
